// file: core/p2m_basic_mgmt.v
// port 2 basic management registers: control, status, identifier words, interrupts
// assumes transceiver status arrives asynchronously and the alias ports run on sys_clk
`include "p2m_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module p2m_basic_mgmt #(
  parameter [15:0] ID_LO_VAL = 16'h5a5a, // arbitrary neutral value
  parameter [15:0] ID_HI_VAL = 16'h00a5  // arbitrary neutral value
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // register port
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // per-port alias access
  input  wire        ctl4_wr,
  input  wire [15:0] ctl4_wdata,
  output wire [15:0] ctl4_image,
  input  wire        sta_alias_wr,
  input  wire [15:0] sta_alias_wdata,
  output wire [15:0] sta_alias_image,
  // transceiver status, asynchronous
  input  wire        phy_link_up,
  input  wire        phy_an_done,
  input  wire        phy_an_speed_100,
  input  wire        phy_an_full,
  input  wire        phy_fef_detect,
  input  wire        phy_fiber_mode,
  // transceiver control
  output reg         far_end_loopback,
  output reg         an_enable,
  output reg         an_restart,
  output reg         power_down,
  output reg         speed_100,
  output reg         full_duplex,
  output reg         crossover_algorithm_select,
  output reg         force_mdix,
  output reg         disable_auto_mdix,
  output reg         fef_disable,
  output reg         tx_disable,
  // interrupt
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // control storage, shared by the control address and both alias ports
  // one register behind every address path, so the aliases can never disagree
  reg [15:0] ctrl_reg;
  reg [15:0] ctrl_next;
  reg        restart_seen_reg;

  // maps the alias layout onto the control word layout
  function [15:0] c4_to_ctrl;
    input [15:0] c4;
    input [15:0] cur;
    begin
      c4_to_ctrl                       = cur;
      c4_to_ctrl[`P2M_CTL_FAR_LOOP]    = c4[`P2M_C4_FAR_LOOP];
      c4_to_ctrl[`P2M_CTL_FORCE_100]   = c4[`P2M_C4_FORCE_100];
      c4_to_ctrl[`P2M_CTL_AN_EN]       = c4[`P2M_C4_AN_EN];
      c4_to_ctrl[`P2M_CTL_PWR_DOWN]    = c4[`P2M_C4_PWR_DOWN];
      c4_to_ctrl[`P2M_CTL_AN_RESTART]  = c4[`P2M_C4_AN_RESTART];
      c4_to_ctrl[`P2M_CTL_FORCE_FULL]  = c4[`P2M_C4_FORCE_FULL];
      c4_to_ctrl[`P2M_CTL_FORCE_MDIX]  = c4[`P2M_C4_FORCE_MDIX];
      c4_to_ctrl[`P2M_CTL_DIS_AMDIX]   = c4[`P2M_C4_DIS_AMDIX];
      c4_to_ctrl[`P2M_CTL_DIS_FEF]     = c4[`P2M_C4_DIS_FEF];
      c4_to_ctrl[`P2M_CTL_TX_DIS]      = c4[`P2M_C4_TX_DIS];
    end
  endfunction

  // maps the control word layout onto the alias layout; bits 15 and 4..0 read zero
  function [15:0] ctrl_to_c4;
    input [15:0] cw;
    begin
      ctrl_to_c4                       = 16'h0000;
      ctrl_to_c4[`P2M_C4_FAR_LOOP]     = cw[`P2M_CTL_FAR_LOOP];
      ctrl_to_c4[`P2M_C4_FORCE_100]    = cw[`P2M_CTL_FORCE_100];
      ctrl_to_c4[`P2M_C4_AN_EN]        = cw[`P2M_CTL_AN_EN];
      ctrl_to_c4[`P2M_C4_PWR_DOWN]     = cw[`P2M_CTL_PWR_DOWN];
      ctrl_to_c4[`P2M_C4_AN_RESTART]   = cw[`P2M_CTL_AN_RESTART];
      ctrl_to_c4[`P2M_C4_FORCE_FULL]   = cw[`P2M_CTL_FORCE_FULL];
      ctrl_to_c4[`P2M_C4_FORCE_MDIX]   = cw[`P2M_CTL_FORCE_MDIX];
      ctrl_to_c4[`P2M_C4_DIS_AMDIX]    = cw[`P2M_CTL_DIS_AMDIX];
      ctrl_to_c4[`P2M_C4_DIS_FEF]      = cw[`P2M_CTL_DIS_FEF];
      ctrl_to_c4[`P2M_C4_TX_DIS]       = cw[`P2M_CTL_TX_DIS];
    end
  endfunction

  // only writable bits survive; reserved and unsupported bits stay zero
  function [15:0] ctrl_keep;
    input [15:0] w;
    begin
      ctrl_keep = 16'h0000;
      ctrl_keep[`P2M_CTL_FAR_LOOP]   = w[`P2M_CTL_FAR_LOOP];
      ctrl_keep[`P2M_CTL_FORCE_100]  = w[`P2M_CTL_FORCE_100];
      ctrl_keep[`P2M_CTL_AN_EN]      = w[`P2M_CTL_AN_EN];
      ctrl_keep[`P2M_CTL_PWR_DOWN]   = w[`P2M_CTL_PWR_DOWN];
      ctrl_keep[`P2M_CTL_AN_RESTART] = w[`P2M_CTL_AN_RESTART];
      ctrl_keep[`P2M_CTL_FORCE_FULL] = w[`P2M_CTL_FORCE_FULL];
      ctrl_keep[`P2M_CTL_XO_ALGO]    = w[`P2M_CTL_XO_ALGO];
      ctrl_keep[`P2M_CTL_FORCE_MDIX] = w[`P2M_CTL_FORCE_MDIX];
      ctrl_keep[`P2M_CTL_DIS_AMDIX]  = w[`P2M_CTL_DIS_AMDIX];
      ctrl_keep[`P2M_CTL_DIS_FEF]    = w[`P2M_CTL_DIS_FEF];
      ctrl_keep[`P2M_CTL_TX_DIS]     = w[`P2M_CTL_TX_DIS];
    end
  endfunction

  // exact decode; partial address matches are refused
  function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  wire wr_ctrl = reg_wr && addr_hit(reg_addr, `P2M_OFS_CTRL);

  always @* begin
    ctrl_next = ctrl_reg;
    if (sta_alias_wr) begin
      ctrl_next[`P2M_CTL_XO_ALGO] = sta_alias_wdata[`P2M_SA_XO_ALGO];
    end
    if (ctl4_wr) begin
      ctrl_next = c4_to_ctrl(ctl4_wdata, ctrl_next);
    end
    if (wr_ctrl) begin
      ctrl_next = reg_wdata;
    end
    if (restart_seen_reg && !(wr_ctrl || ctl4_wr)) begin
      ctrl_next[`P2M_CTL_AN_RESTART] = 1'b0;
    end
    ctrl_next = ctrl_keep(ctrl_next);
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg         <= `P2M_CTL_RESET;
      restart_seen_reg <= 1'b0;
    end else begin
      ctrl_reg         <= ctrl_next;
      restart_seen_reg <= ctrl_reg[`P2M_CTL_AN_RESTART] && !restart_seen_reg;
    end
  end

  assign ctl4_image = ctrl_to_c4(ctrl_reg);

  ////////////////////////////////////////////////////////////////////////////
  // transceiver status synchronisers
  // two flops per input; nothing but the second flop is read
  localparam SYNC_W = 6;
  wire [SYNC_W-1:0] sync_in = {phy_fiber_mode, phy_fef_detect, phy_an_full,
                               phy_an_speed_100, phy_an_done, phy_link_up};
  wire [SYNC_W-1:0] sync_out;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      reg meta_reg;
      reg stab_reg;
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg <= 1'b0;
          stab_reg <= 1'b0;
        end else begin
          meta_reg <= sync_in[gi];
          stab_reg <= meta_reg;
        end
      end
      assign sync_out[gi] = stab_reg;
    end
  endgenerate

  wire link_s   = sync_out[0];
  wire an_done_s = sync_out[1];
  wire an_100_s = sync_out[2];
  wire an_fd_s  = sync_out[3];
  wire fef_s    = sync_out[4];
  wire fiber_s  = sync_out[5];

  // complete only while negotiation runs and has finished
  wire an_cmpl = an_done_s && ctrl_reg[`P2M_CTL_AN_EN];
  // fault shown only in fiber mode with detection enabled
  wire fef_hit = fef_s && fiber_s && !ctrl_reg[`P2M_CTL_DIS_FEF];

  reg [15:0] stat_word;
  always @* begin
    stat_word = `P2M_STA_CAP_MASK;
    stat_word[`P2M_STA_AN_DONE] = an_cmpl;
    stat_word[`P2M_STA_FEF]     = fef_hit;
    stat_word[`P2M_STA_LINK]    = link_s;
    stat_word[`P2M_STA_EXT_CAP] = `P2M_EXT_CAP_VAL;
  end

  reg [15:0] sta_img_word;
  always @* begin
    sta_img_word                  = 16'h0000;
    sta_img_word[`P2M_SA_XO_ALGO] = ctrl_reg[`P2M_CTL_XO_ALGO];
    sta_img_word[`P2M_SA_FEF]     = fef_hit;
    sta_img_word[`P2M_SA_AN_DONE] = an_cmpl;
    sta_img_word[`P2M_SA_LINK]    = link_s;
  end
  assign sta_alias_image = sta_img_word;

  ////////////////////////////////////////////////////////////////////////////
  // transceiver control outputs
  // forced or negotiated mode
  // forced values count only while negotiation is off; unfinished negotiation is half duplex
  reg speed_sel;
  reg duplex_sel;
  always @* begin
    if (ctrl_reg[`P2M_CTL_AN_EN]) begin
      speed_sel  = an_100_s;
      duplex_sel = an_done_s && an_fd_s;
    end else begin
      speed_sel  = ctrl_reg[`P2M_CTL_FORCE_100];
      duplex_sel = ctrl_reg[`P2M_CTL_FORCE_FULL];
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      far_end_loopback           <= 1'b0;
      an_enable                  <= 1'b0;
      an_restart                 <= 1'b0;
      power_down                 <= 1'b0;
      speed_100                  <= 1'b0;
      full_duplex                <= 1'b0;
      crossover_algorithm_select <= 1'b0;
      force_mdix                 <= 1'b0;
      disable_auto_mdix          <= 1'b0;
      fef_disable                <= 1'b0;
      tx_disable                 <= 1'b0;
    end else begin
      far_end_loopback           <= ctrl_reg[`P2M_CTL_FAR_LOOP];
      an_enable                  <= ctrl_reg[`P2M_CTL_AN_EN];
      an_restart                 <= restart_seen_reg;
      power_down                 <= ctrl_reg[`P2M_CTL_PWR_DOWN];
      speed_100                  <= speed_sel;
      // failed or unfinished negotiation is half duplex
      full_duplex                <= duplex_sel;
      crossover_algorithm_select <= ctrl_reg[`P2M_CTL_XO_ALGO];
      force_mdix                 <= ctrl_reg[`P2M_CTL_FORCE_MDIX];
      disable_auto_mdix          <= ctrl_reg[`P2M_CTL_DIS_AMDIX];
      fef_disable                <= ctrl_reg[`P2M_CTL_DIS_FEF];
      tx_disable                 <= ctrl_reg[`P2M_CTL_TX_DIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, set wins over a write-one clear
  reg  [`P2M_INT_W-1:0] int_stat_reg;
  reg  [`P2M_INT_W-1:0] int_mask_reg;
  reg                   link_d_reg;
  reg                   an_d_reg;
  reg                   fef_d_reg;
  wire [`P2M_INT_W-1:0] int_evt;
  wire                  wr_istat = reg_wr && addr_hit(reg_addr, `P2M_OFS_INT_STAT);
  wire                  wr_imask = reg_wr && addr_hit(reg_addr, `P2M_OFS_INT_MASK);

  assign int_evt[`P2M_INT_LINK_CHG] = link_s ^ link_d_reg;
  assign int_evt[`P2M_INT_AN_DONE]  = an_cmpl && !an_d_reg;
  assign int_evt[`P2M_INT_FEF]      = fef_hit && !fef_d_reg;

  reg  [`P2M_INT_W-1:0] int_clr;
  reg  [`P2M_INT_W-1:0] int_stat_next;
  // set wins: an event in the clearing cycle is not lost
  always @* begin
    int_clr = {`P2M_INT_W{1'b0}};
    if (wr_istat) begin
      int_clr = reg_wdata[`P2M_INT_W-1:0];
    end
    int_stat_next = (int_stat_reg & ~int_clr) | int_evt;
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_stat_reg <= {`P2M_INT_W{1'b0}};
      int_mask_reg <= {`P2M_INT_W{1'b0}};
      link_d_reg   <= 1'b0;
      an_d_reg     <= 1'b0;
      fef_d_reg    <= 1'b0;
      irq          <= 1'b0;
    end else begin
      link_d_reg   <= link_s;
      an_d_reg     <= an_cmpl;
      fef_d_reg    <= fef_hit;
      int_stat_reg <= int_stat_next;
      if (wr_imask) begin
        int_mask_reg <= reg_wdata[`P2M_INT_W-1:0];
      end
      // from a flop, so irq lags the status by one cycle but never glitches
      irq          <= |(int_stat_reg & int_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stands only in the cycle after the strobe
  reg [15:0] rd_mux;
  always @* begin
    case (reg_addr)
      `P2M_OFS_CTRL:     rd_mux = ctrl_reg;
      `P2M_OFS_STAT:     rd_mux = stat_word;
      `P2M_OFS_ID_LO:    rd_mux = ID_LO_VAL;
      `P2M_OFS_ID_HI:    rd_mux = ID_HI_VAL;
      `P2M_OFS_INT_STAT: rd_mux = {13'h0000, int_stat_reg};
      `P2M_OFS_INT_MASK: rd_mux = {13'h0000, int_mask_reg};
      default:           rd_mux = 16'h0000;
    endcase
  end

  reg [15:0] rdata_next;
  // zero outside the answer cycle so stale data never looks valid
  always @* begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      rdata_next = rd_mux;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// file: shared/p2m_defs.vh
// register offsets, field positions and reset values of the port 2 basic management bank
// assumes a 12-bit byte address and 16-bit register data
`ifndef P2M_DEFS_VH
`define P2M_DEFS_VH

// register offsets
`define P2M_OFS_CTRL        12'h058
`define P2M_OFS_STAT        12'h05a
`define P2M_OFS_ID_LO       12'h05c
`define P2M_OFS_ID_HI       12'h05e
`define P2M_OFS_INT_STAT    12'h0f0
`define P2M_OFS_INT_MASK    12'h0f2

// basic control word fields
`define P2M_CTL_FAR_LOOP    14
`define P2M_CTL_FORCE_100   13
`define P2M_CTL_AN_EN       12
`define P2M_CTL_PWR_DOWN    11
`define P2M_CTL_AN_RESTART  9
`define P2M_CTL_FORCE_FULL  8
`define P2M_CTL_XO_ALGO     5
`define P2M_CTL_FORCE_MDIX  4
`define P2M_CTL_DIS_AMDIX   3
`define P2M_CTL_DIS_FEF     2
`define P2M_CTL_TX_DIS      1
`define P2M_CTL_RESET       16'h3120

// basic status word fields
`define P2M_STA_CAP_MASK    16'h7808
`define P2M_STA_AN_DONE     5
`define P2M_STA_FEF         4
`define P2M_STA_LINK        2
`define P2M_STA_EXT_CAP     0
`define P2M_EXT_CAP_VAL     1'b0

// per-port control four alias positions
`define P2M_C4_FAR_LOOP     8
`define P2M_C4_FORCE_100    6
`define P2M_C4_AN_EN        7
`define P2M_C4_PWR_DOWN     11
`define P2M_C4_AN_RESTART   13
`define P2M_C4_FORCE_FULL   5
`define P2M_C4_FORCE_MDIX   9
`define P2M_C4_DIS_AMDIX    10
`define P2M_C4_DIS_FEF      12
`define P2M_C4_TX_DIS       14

// per-port status alias positions
`define P2M_SA_XO_ALGO      15
`define P2M_SA_FEF          8
`define P2M_SA_AN_DONE      6
`define P2M_SA_LINK         5

// interrupt status and mask fields
`define P2M_INT_LINK_CHG    0
`define P2M_INT_AN_DONE     1
`define P2M_INT_FEF         2
`define P2M_INT_W           3

`endif

// file: verif/p2m_checker.sv
// assertions for the port 2 basic management bank
// assumes it is bound onto p2m_basic_mgmt and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module p2m_checker #(
  parameter [15:0] ID_LO_VAL = 16'h5a5a, // arbitrary value
  parameter [15:0] ID_HI_VAL = 16'h00a5  // arbitrary value
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // alias port and negotiation status
  input wire logic        ctl4_wr,
  input wire logic [15:0] ctl4_wdata,
  input wire logic [15:0] ctl4_image,
  input wire logic        phy_an_done,
  // transceiver control
  input wire logic        far_end_loopback,
  input wire logic        an_enable,
  input wire logic        an_restart,
  input wire logic        power_down,
  input wire logic        speed_100,
  input wire logic        full_duplex,
  input wire logic        crossover_algorithm_select,
  input wire logic        force_mdix,
  input wire logic        disable_auto_mdix,
  input wire logic        fef_disable,
  input wire logic        tx_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////
  sequence s_cw; reg_wr && reg_addr == 12'h058; endsequence
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_pulse; !an_restart [*3] ##1 an_restart ##1 !an_restart; endsequence
  property p_status; s_rd(12'h05a) |=> (reg_rdata & 16'hf809) == 16'h7808; endproperty
  property p_id_lo; s_rd(12'h05c) |=> reg_rdata == ID_LO_VAL; endproperty
  property p_id_hi; s_rd(12'h05e) |=> reg_rdata == ID_HI_VAL; endproperty
  property p_restart; s_cw ##0 reg_wdata[9] |-> s_pulse; endproperty
  property p_loop; s_cw |-> ##2 far_end_loopback == $past(reg_wdata[14], 2) && tx_disable == $past(reg_wdata[1], 2);
  endproperty
  property p_xo; s_cw |-> ##2 crossover_algorithm_select == $past(reg_wdata[5], 2)
    && force_mdix == $past(reg_wdata[4], 2) && disable_auto_mdix == $past(reg_wdata[3], 2); endproperty
  property p_pd; s_cw |-> ##2 power_down == $past(reg_wdata[11], 2) && fef_disable == $past(reg_wdata[2], 2);
  endproperty
  property p_forced; s_cw ##0 !reg_wdata[12] |-> ##2 !an_enable && speed_100 == $past(reg_wdata[13], 2)
    && full_duplex == $past(reg_wdata[8], 2); endproperty
  property p_half; (an_enable && !phy_an_done) [*4] |-> !full_duplex; endproperty
  property p_alias; ctl4_wr && !reg_wr |=> ctl4_image[14:5] == $past(ctl4_wdata[14:5]); endproperty
  a_status: assert property (p_status) else $error("status constant bits wrong");
  a_id_lo: assert property (p_id_lo) else $error("low identifier wrong");
  a_id_hi: assert property (p_id_hi) else $error("high identifier wrong");
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  a_loop: assert property (p_loop) else $error("loopback or tx disable wrong");
  a_xo: assert property (p_xo) else $error("crossover controls wrong");
  a_pd: assert property (p_pd) else $error("power down or fault disable wrong");
  a_forced: assert property (p_forced) else $error("forced speed or duplex wrong");
  a_half: assert property (p_half) else $error("full duplex without negotiation");
  a_alias: assert property (p_alias) else $error("alias write not visible");
endmodule
bind p2m_basic_mgmt p2m_checker #(.ID_LO_VAL(ID_LO_VAL), .ID_HI_VAL(ID_HI_VAL)) p2m_checker_i (.sys_clk, .arst_n,
  .reg_wr, .reg_rd, .ctl4_wr, .phy_an_done, .reg_addr, .reg_wdata, .reg_rdata, .ctl4_wdata, .ctl4_image,
  .far_end_loopback, .an_enable, .an_restart, .power_down, .speed_100, .full_duplex, .crossover_algorithm_select,
  .force_mdix, .disable_auto_mdix, .fef_disable, .tx_disable);
`default_nettype wire

// file: verif/phy2_basic_mgmt_regs_test.sv
// self-checking bench for the port 2 basic management bank
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
module phy2_basic_mgmt_regs_test;
  localparam [15:0] ID_LO = 16'h3c3c; // arbitrary value
  localparam [15:0] ID_HI = 16'h00c3; // arbitrary value
  logic        sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, ctl4_wr = 0, sta_alias_wr = 0, rd_q = 0;
  logic        phy_link_up = 0, phy_an_done = 0, phy_an_speed_100 = 0, phy_an_full = 0;
  logic        phy_fef_detect = 0, phy_fiber_mode = 0;
  logic [11:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, ctl4_wdata = '0, sta_alias_wdata = '0, d;
  wire  [15:0] reg_rdata, ctl4_image, sta_img;
  wire  [7:0]  o;
  wire         an_restart, speed_100, full_duplex, irq;
  logic [15:0] exp_q[$], msk_q[$];
  int          n_fail = 0, total_checks = 0, k;
  always #2.5 sys_clk = ~sys_clk;
  p2m_basic_mgmt #(.ID_LO_VAL(ID_LO), .ID_HI_VAL(ID_HI)) p2m_basic_mgmt_i (.sys_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctl4_wr, .ctl4_wdata, .ctl4_image, .sta_alias_wr, .sta_alias_wdata,
    .sta_alias_image(sta_img), .phy_link_up, .phy_an_done, .phy_an_speed_100, .phy_an_full, .phy_fef_detect,
    .phy_fiber_mode, .far_end_loopback(o[0]), .an_enable(o[1]), .an_restart, .power_down(o[3]), .speed_100,
    .full_duplex, .crossover_algorithm_select(o[2]), .force_mdix(o[4]), .disable_auto_mdix(o[5]),
    .fef_disable(o[6]), .tx_disable(o[7]), .irq);
  //////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // reads note their expectation; the monitor below compares it
  task automatic op(logic w, logic [11:0] a, logic [15:0] v, logic [15:0] m = 16'hffff);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    if (!w) begin
      exp_q.push_back(v & m);
      msk_q.push_back(m);
    end
    @(posedge sys_clk);
  endtask
  task automatic idle(int n);
    reg_wr <= 0;
    reg_rd <= 0;
    ctl4_wr <= 0;
    sta_alias_wr <= 0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read data stand one cycle only, so look mid-cycle
  always @(posedge sys_clk) rd_q <= reg_rd;
  always @(negedge sys_clk) if (rd_q === 1'b1) chk("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  //////////////////////////////////////////////////
  initial begin
    k = $urandom(15850);
    repeat (3) @(posedge sys_clk);
    arst_n <= 1;
    @(posedge sys_clk);
    op(0, 12'h058, 16'h3120);
    op(0, 12'h05a, 16'h7808, 16'hf80f);
    op(1, 12'h05c, 16'hffff);
    op(1, 12'h05e, 16'h0000);
    op(0, 12'h05c, ID_LO);
    op(0, 12'h05e, ID_HI);
    op(0, 12'h100, 16'h0000);
    op(0, 12'h0f2, 16'h0000);
    idle(2);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom) & 16'h793e;
      op(1, 12'h058, d);
      op(0, 12'h058, d);
      idle(1);
      chk("ctl4_image", {1'b0, d[1], 1'b0, d[2], d[11], d[3], d[4], d[14], d[12], d[13], d[8], 5'h0}, ctl4_image);
    end
    $display("test random_control done");
    op(1, 12'h058, 16'h1200);
    idle(0);
    k = 0;
    repeat (6) begin
      @(negedge sys_clk);
      k += (an_restart === 1'b1);
    end
    chk("restart pulses", 16'h0001, 16'(k));
    @(posedge sys_clk);
    op(0, 12'h058, 16'h1000);
    idle(1);
    $display("test restart done");
    ctl4_wr <= 1;
    ctl4_wdata <= 16'h0900;
    @(posedge sys_clk);
    ctl4_wr <= 0;
    sta_alias_wr <= 1;
    sta_alias_wdata <= 16'h8000;
    @(posedge sys_clk);
    idle(1);
    chk("sta_alias_image", 16'h8000, sta_img);
    op(0, 12'h058, 16'h4820);
    idle(1);
    chk("power_down xo_select", 16'h0003, {14'h0, o[3], o[2]});
    $display("test alias done");
    op(1, 12'h058, 16'h1000);
    {phy_link_up, phy_an_done, phy_an_speed_100, phy_an_full, phy_fef_detect, phy_fiber_mode} <= 6'h3f;
    idle(5);
    op(0, 12'h05a, 16'h783c);
    chk("sta_alias_image", 16'h0160, sta_img);
    op(1, 12'h058, 16'h1004);
    idle(2);
    op(0, 12'h05a, 16'h782c);
    op(0, 12'h0f0, 16'h0007);
    idle(2);
    chk("irq masked", 16'h0000, {15'h0, irq});
    op(1, 12'h0f2, 16'h0002);
    idle(2);
    chk("irq unmasked", 16'h0001, {15'h0, irq});
    op(1, 12'h0f0, 16'h0007);
    idle(2);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    phy_link_up <= 0;
    phy_an_done <= 0;
    idle(5);
    chk("failed negotiation duplex", 16'h0000, {15'h0, full_duplex});
    op(0, 12'h0f0, 16'h0001);
    op(0, 12'h05a, 16'h7808, 16'hfffc);
    idle(1);
    $display("test status_irq done");
    op(1, 12'h058, 16'h0100);
    idle(2);
    chk("forced speed duplex", 16'h0001, {14'h0, speed_100, full_duplex});
    $display("test forced done");
    arst_n <= 0;
    idle(2);
    arst_n <= 1;
    idle(1);
    op(0, 12'h058, 16'h3120);
    idle(1);
    $display("test second_reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
